// ### logic/phyc_pkg.sv
// Shared constants and carrier types for the PHY control register bank.
// Assumes a single 125 MHz clock and a clause 22 management bus whose MDC
// and MDIO levels arrive synchronous to that clock.
package phyc_pkg;

  // Management register indices on the clause 22 bus.
  localparam logic [4:0] REG_ACC_CTL = 5'h0d;
  localparam logic [4:0] REG_PORTAL  = 5'h0e;
  localparam logic [4:0] REG_CTL2    = 5'h1f;

  // Field positions of the second control register.
  localparam int CTL2_XVAR   = 15;
  localparam int CTL2_MANX   = 14;
  localparam int CTL2_PSWAP  = 13;
  localparam int CTL2_FLINK  = 11;
  localparam int CTL2_PSAVE  = 10;
  localparam int CTL2_INTPOL = 9;
  localparam int CTL2_JAB    = 8;
  localparam int CTL2_LED_HI = 5;
  localparam int CTL2_LED_LO = 4;
  localparam int CTL2_TXDIS  = 3;
  localparam int CTL2_RLOOP  = 2;
  localparam int CTL2_SQE    = 1;
  localparam int CTL2_SCRBYP = 0;

  // Fixed reset bits: variant select and jabber enable set, rest clear.
  localparam logic [15:0] CTL2_RST = 16'h8100;

  // Indicator mode codes.
  localparam logic [1:0] LED_SPD_LNKACT = 2'h0;
  localparam logic [1:0] LED_ACT_LNK    = 2'h1;

  // Access control register layout and reset values.
  localparam int          ACC_FN_HI  = 15;
  localparam int          ACC_FN_LO  = 14;
  localparam int          ACC_MID_HI = 13;
  localparam int          ACC_MID_LO = 5;
  localparam int          ACC_DEV_HI = 4;
  localparam logic [1:0]  FN_RST     = 2'h0;
  localparam logic [4:0]  EXTENDED_DEVICE_SELECTOR_RST  = 5'h00;
  localparam logic [15:0] PTR_RST    = 16'h0000;

  // Portal function codes.
  localparam logic [1:0] FN_ADDR   = 2'h0;
  localparam logic [1:0] FN_DATA   = 2'h1;
  localparam logic [1:0] FN_INC_RW = 2'h2;
  localparam logic [1:0] FN_INC_W  = 2'h3;

  // Extended space: 32 devices, 16-bit addresses, 16-bit words.
  localparam int NUM_DEV   = 32;
  localparam int STORE_AW  = 4;
  localparam int STORE_DEP = 16;

  // Management frame layout.
  localparam logic [1:0] OP_RD     = 2'h2;
  localparam logic [1:0] OP_WR     = 2'h1;
  localparam logic [4:0] HDR_LAST  = 5'h0b;
  localparam logic [4:0] DATA_LAST = 5'h0f;

  typedef logic [1:0] phyc_func_t;

  typedef enum logic [4:0] {
    MS_IDLE  = 5'b00001,
    MS_HDR   = 5'b00010,
    MS_TA    = 5'b00100,
    MS_RDATA = 5'b01000,
    MS_WDATA = 5'b10000
  } phyc_mstate_e;

  // Register request from the serial front end.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  regad;
    logic [15:0] wdata;
  } phyc_mreq_s;

  // Link indications feeding the indicator outputs.
  typedef struct packed {
    logic speed_100;
    logic link_up;
    logic activity;
  } phyc_led_s;

  // Control levels handed to the analog and link logic.
  typedef struct packed {
    logic crossover_variant_select;
    logic auto_xover_en;
    logic tx_on_rx_pair;
    logic force_link;
    logic power_save;
    logic jabber_en;
    logic tx_disable;
    logic remote_loop;
    logic sqe_test;
    logic scram_bypass;
  } phyc_cfg_s;

endpackage : phyc_pkg

// ### logic/phyc_mdio.sv
// Serial management front end: turns clause 22 frames into register requests.
// Assumes MDC and MDIO input are synchronous to mclk and MDC is slower than
// a quarter of mclk.
`timescale 1ns/1ps

module phyc_mdio (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // Station address
  input  wire logic [4:0]        phy_addr,
  // Management pins
  input  wire logic              mdc,
  input  wire logic              mdio_in,
  output logic                   mdio_out,
  output logic                   mdio_oe_n,
  // Register side
  output phyc_pkg::phyc_mreq_s   req,
  input  wire logic [15:0]       rdata
);
  import phyc_pkg::*;

  typedef struct packed {
    phyc_mstate_e st;
    logic         mdc_q;
    logic [15:0]  sh;
    logic [4:0]   cnt;
    logic         is_rd;
    logic         dout;
    logic         oe_n;
    phyc_mreq_s   req;
  } phyc_mdio_s;

  phyc_mdio_s s_r;
  phyc_mdio_s s_nxt;
  logic       rise;
  logic [11:0] hdr;

  assign rise = mdc & ~s_r.mdc_q;
  assign hdr  = {s_r.sh[10:0], mdio_in};

  always_comb begin
    s_nxt        = s_r;
    s_nxt.mdc_q  = mdc;
    s_nxt.req.rd = 1'b0;
    s_nxt.req.wr = 1'b0;
    if (rise) begin
      unique case (s_r.st)
        MS_IDLE: begin
          s_nxt.sh = {s_r.sh[14:0], mdio_in};
          // Two preamble ones, then the 0 1 start pattern.
          if (s_r.sh[2:0] == 3'h6 && mdio_in) begin
            s_nxt.st  = MS_HDR;
            s_nxt.cnt = 5'h00;
          end
        end
        MS_HDR: begin
          s_nxt.sh  = {s_r.sh[14:0], mdio_in};
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == HDR_LAST) begin
            s_nxt.cnt       = 5'h00;
            s_nxt.req.regad = hdr[4:0];
            s_nxt.is_rd     = (hdr[11:10] == OP_RD);
            s_nxt.st        = MS_IDLE;
            s_nxt.sh        = '1;
            // Frames for another station are dropped after the header; the rest is scanned for a new start.
            if (hdr[9:5] == phy_addr &&
                (hdr[11:10] == OP_RD || hdr[11:10] == OP_WR)) begin
              s_nxt.st     = MS_TA;
              s_nxt.req.rd = (hdr[11:10] == OP_RD);
            end
          end
        end
        MS_TA: begin
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == 5'h00 && s_r.is_rd) begin
            s_nxt.oe_n = 1'b0;
            s_nxt.dout = 1'b0;
          end else if (s_r.cnt != 5'h00) begin
            s_nxt.cnt = 5'h00;
            if (s_r.is_rd) begin
              s_nxt.sh   = rdata;
              s_nxt.dout = rdata[15];
              s_nxt.st   = MS_RDATA;
            end else begin
              s_nxt.st = MS_WDATA;
            end
          end
        end
        MS_RDATA: begin
          s_nxt.cnt = s_r.cnt + 5'h01;
          s_nxt.sh  = {s_r.sh[14:0], 1'b1};
          s_nxt.dout = s_r.sh[14];
          if (s_r.cnt == DATA_LAST) begin
            s_nxt.oe_n = 1'b1;
            s_nxt.sh   = '1;
            s_nxt.st   = MS_IDLE;
          end
        end
        MS_WDATA: begin
          s_nxt.sh  = {s_r.sh[14:0], mdio_in};
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == DATA_LAST) begin
            s_nxt.req.wr    = 1'b1;
            s_nxt.req.wdata = {s_r.sh[14:0], mdio_in};
            s_nxt.sh        = '1;
            s_nxt.st        = MS_IDLE;
          end
        end
      endcase
    end
    if (srst) begin
      s_nxt       = '0;
      s_nxt.st    = MS_IDLE;
      s_nxt.sh    = '1;
      s_nxt.oe_n  = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  assign mdio_out  = s_r.dout;
  assign mdio_oe_n = s_r.oe_n;
  assign req       = s_r.req;

endmodule : phyc_mdio

// ### logic/phyc_mmd_store.sv
// Flip-flop store standing in for the extended register contents.
// Assumes one write per cycle; read is a plain index into the flops.
`timescale 1ns/1ps

module phyc_mmd_store (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          srst,
  // Access
  input  wire logic                          wr,
  input  wire logic [phyc_pkg::STORE_AW-1:0] idx,
  input  wire logic [15:0]                   wdata,
  output logic      [15:0]                   rdata
);
  import phyc_pkg::*;

  typedef struct packed {
    logic [STORE_DEP-1:0][15:0] mem;
  } phyc_store_s;

  phyc_store_s s_r;
  phyc_store_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (wr) begin
      s_nxt.mem[idx] = wdata;
    end
    if (srst) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  assign rdata = s_r.mem[idx];

  property p_store_wr;
    @(posedge mclk) disable iff (srst)
    wr |=> s_r.mem[$past(idx)] == $past(wdata);
  endproperty
  a_store_wr: assert property (p_store_wr)
    else $error("Store write did not land.");

endmodule : phyc_mmd_store

// ### logic/phyc_top.sv
// Management register bank of a 10/100 transceiver: second control register
// and the indirect access portal into the extended register space.
// Assumes the management pins are synchronous to mclk and that the pad
// resolves MDIO from mdio_out and mdio_oe_n.
//
// Function
// - Variant select chooses one of two crossover algorithms; resets to one.
// - Manual crossover bit swaps pairs when automatic crossover is off.
// - Pair swap disable turns automatic crossover off; reset from strap.
// - Force link bypasses link control so the transmitter keeps sending.
// - Power saving bit enables power saving; resets to zero.
// - Interrupt polarity bit selects active high or low; low at reset.
// - Jabber enable bit enables the jabber counter; resets to one.
// - Two-bit indicator mode maps speed, link and activity to two outputs.
// - Transmitter disable bit switches the line driver off; resets to zero.
// - Remote loopback bit loops line receive data back to the line.
// - Scrambler bypass bit disables the scrambler; cleared at reset.
// - Extended space addresses 32 devices of 65,536 registers; only 16 sixteen-bit words are backed by flops.
// - Function field picks address, data, or data with post-increment.
// - Low five control bits select the extended device; reset to zero.
// - Address function makes the portal reach the device address pointer.
// - Data functions make the portal reach the register at the pointer.
// - Increment on reads and writes lets successive reads walk a block.
`timescale 1ns/1ps

module phyc_top #(
  parameter logic [1:0] LED_MODE_RST = phyc_pkg::LED_ACT_LNK
) (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           srst,
  // Straps and station address
  input  wire logic           strap_pair_swap_dis,
  input  wire logic [4:0]     phy_addr,
  // Management pins
  input  wire logic           mdc,
  input  wire logic           mdio_in,
  output logic                mdio_out,
  output logic                mdio_oe_n,
  // Link state and events
  input  wire logic           int_req,
  input  phyc_pkg::phyc_led_s led_in,
  // Control levels and pins
  output phyc_pkg::phyc_cfg_s cfg,
  output logic                int_pin,
  output logic                indicator_one,
  output logic                indicator_zero
);
  import phyc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [15:0]               ctl2;
    phyc_func_t                fn;
    logic [8:0]                mid;
    logic [4:0]                extended_device_selector;
    logic [NUM_DEV-1:0][15:0]  ptr;
    logic [15:0]               rdata;
    phyc_cfg_s                 cfg;
    logic                      int_pin;
    logic                      ind1;
    logic                      ind0;
  } phyc_top_s;

  phyc_top_s              s_r;
  phyc_top_s              s_nxt;
  phyc_mreq_s             req;
  logic [15:0]            store_rdata;
  logic                   store_wr;
  logic [STORE_AW-1:0]    store_idx;
  logic                   portal_hit_rd;
  logic                   portal_hit_wr;

  // Only a slice of each device is backed by flops; the index folds the
  // device and pointer so that distinct low addresses stay distinct.
  function automatic logic [STORE_AW-1:0] store_index(
    input logic [4:0]  dev,
    input logic [15:0] ptr
  );
    store_index = {dev[1:0], ptr[1:0]};
  endfunction

  function automatic logic [15:0] ptr_inc(input logic [15:0] ptr);
    ptr_inc = ptr + 16'h0001;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  phyc_mdio u_mdio (
    .mclk      (mclk),
    .srst      (srst),
    .phy_addr  (phy_addr),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe_n (mdio_oe_n),
    .req       (req),
    .rdata     (s_r.rdata)
  );

  assign portal_hit_rd = req.rd && req.regad == REG_PORTAL;
  assign portal_hit_wr = req.wr && req.regad == REG_PORTAL;
  assign store_idx     = store_index(s_r.extended_device_selector, s_r.ptr[s_r.extended_device_selector]);
  assign store_wr      = portal_hit_wr && s_r.fn != FN_ADDR;

  phyc_mmd_store u_store (
    .mclk  (mclk),
    .srst  (srst),
    .wr    (store_wr),
    .idx   (store_idx),
    .wdata (req.wdata),
    .rdata (store_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_nxt = s_r;
    if (req.rd) begin
      unique case (req.regad)
        REG_ACC_CTL: s_nxt.rdata = {s_r.fn, s_r.mid, s_r.extended_device_selector};
        REG_PORTAL: begin
          // Read data is caught before the pointer moves.
          s_nxt.rdata = (s_r.fn == FN_ADDR) ? s_r.ptr[s_r.extended_device_selector]
                                            : store_rdata;
          if (s_r.fn == FN_INC_RW) begin
            s_nxt.ptr[s_r.extended_device_selector] = ptr_inc(s_r.ptr[s_r.extended_device_selector]);
          end
        end
        REG_CTL2:    s_nxt.rdata = s_r.ctl2;
        default:     s_nxt.rdata = 16'h0000;
      endcase
    end
    if (req.wr) begin
      unique case (req.regad)
        REG_ACC_CTL: begin
          s_nxt.fn    = req.wdata[ACC_FN_HI:ACC_FN_LO];
          s_nxt.mid   = req.wdata[ACC_MID_HI:ACC_MID_LO];
          s_nxt.extended_device_selector = req.wdata[ACC_DEV_HI:0];
        end
        REG_PORTAL: begin
          if (s_r.fn == FN_ADDR) begin
            s_nxt.ptr[s_r.extended_device_selector] = req.wdata;
          end else if (s_r.fn != FN_DATA) begin
            s_nxt.ptr[s_r.extended_device_selector] = ptr_inc(s_r.ptr[s_r.extended_device_selector]);
          end
        end
        REG_CTL2:    s_nxt.ctl2 = req.wdata;
        default:     s_nxt.ctl2 = s_r.ctl2;
      endcase
    end

    // Control levels follow the stored bits one cycle later.
    s_nxt.cfg.crossover_variant_select = s_r.ctl2[CTL2_XVAR];
    s_nxt.cfg.auto_xover_en = ~s_r.ctl2[CTL2_PSWAP];
    s_nxt.cfg.tx_on_rx_pair = s_r.ctl2[CTL2_PSWAP] &
                              s_r.ctl2[CTL2_MANX];
    s_nxt.cfg.force_link    = s_r.ctl2[CTL2_FLINK];
    s_nxt.cfg.power_save    = s_r.ctl2[CTL2_PSAVE];
    s_nxt.cfg.jabber_en     = s_r.ctl2[CTL2_JAB];
    s_nxt.cfg.tx_disable    = s_r.ctl2[CTL2_TXDIS];
    s_nxt.cfg.remote_loop   = s_r.ctl2[CTL2_RLOOP];
    s_nxt.cfg.sqe_test      = s_r.ctl2[CTL2_SQE];
    s_nxt.cfg.scram_bypass  = s_r.ctl2[CTL2_SCRBYP];

    s_nxt.int_pin = s_r.ctl2[CTL2_INTPOL] ? int_req : ~int_req;

    // Reserved indicator codes leave both outputs dark.
    unique case (s_r.ctl2[CTL2_LED_HI:CTL2_LED_LO])
      LED_SPD_LNKACT: begin
        s_nxt.ind1 = led_in.speed_100;
        s_nxt.ind0 = led_in.link_up | led_in.activity;
      end
      LED_ACT_LNK: begin
        s_nxt.ind1 = led_in.activity;
        s_nxt.ind0 = led_in.link_up;
      end
      default: begin
        s_nxt.ind1 = 1'b0;
        s_nxt.ind0 = 1'b0;
      end
    endcase

    if (srst) begin
      s_nxt       = '0;
      s_nxt.ctl2  = CTL2_RST;
      s_nxt.ctl2[CTL2_PSWAP] = strap_pair_swap_dis;
      s_nxt.ctl2[CTL2_LED_HI:CTL2_LED_LO] = LED_MODE_RST;
      s_nxt.fn    = FN_RST;
      s_nxt.extended_device_selector = EXTENDED_DEVICE_SELECTOR_RST;
      s_nxt.ptr   = {NUM_DEV{PTR_RST}};
      s_nxt.int_pin = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  assign cfg            = s_r.cfg;
  assign int_pin        = s_r.int_pin;
  assign indicator_one  = s_r.ind1;
  assign indicator_zero = s_r.ind0;

  //////////////////////////////////////////////////////////////////////////////

  property p_ctl2_levels;
    @(posedge mclk) disable iff (srst)
    req.wr && req.regad == REG_CTL2 |=> ##1
      cfg.force_link == $past(req.wdata[CTL2_FLINK], 2) &&
      cfg.power_save == $past(req.wdata[CTL2_PSAVE], 2) &&
      cfg.tx_disable == $past(req.wdata[CTL2_TXDIS], 2);
  endproperty
  a_ctl2_levels: assert property (p_ctl2_levels)
    else $error("Control levels do not follow a register write.");

  property p_pair_swap;
    @(posedge mclk) disable iff (srst)
    req.wr && req.regad == REG_CTL2 |=> ##1
      cfg.auto_xover_en == !$past(req.wdata[CTL2_PSWAP], 2);
  endproperty
  a_pair_swap: assert property (p_pair_swap)
    else $error("Automatic crossover enable wrong after write.");

  property p_manual_x;
    @(posedge mclk) disable iff (srst)
    req.wr && req.regad == REG_CTL2 |=> ##1
      cfg.tx_on_rx_pair == ($past(req.wdata[CTL2_PSWAP], 2) &&
                            $past(req.wdata[CTL2_MANX], 2));
  endproperty
  a_manual_x: assert property (p_manual_x)
    else $error("Manual pair assignment wrong after write.");

  property p_int_pol;
    @(posedge mclk) disable iff (srst)
    s_r.ctl2[CTL2_INTPOL] && !$past(srst) |=> int_pin == $past(int_req);
  endproperty
  a_int_pol: assert property (p_int_pol)
    else $error("Interrupt pin polarity wrong.");

  property p_led_mode;
    @(posedge mclk) disable iff (srst)
    s_r.ctl2[CTL2_LED_HI:CTL2_LED_LO] == LED_ACT_LNK |=>
      indicator_one == $past(led_in.activity) &&
      indicator_zero == $past(led_in.link_up);
  endproperty
  a_led_mode: assert property (p_led_mode)
    else $error("Indicator mapping wrong.");

  property p_inc_rd;
    @(posedge mclk) disable iff (srst)
    portal_hit_rd && s_r.fn == FN_INC_RW |=>
      s_r.ptr[$past(s_r.extended_device_selector)] == $past(s_r.ptr[s_r.extended_device_selector]) + 16'h0001;
  endproperty
  a_inc_rd: assert property (p_inc_rd)
    else $error("Pointer did not advance after a read.");

  property p_no_inc;
    @(posedge mclk) disable iff (srst)
    portal_hit_rd && s_r.fn != FN_INC_RW |=> $stable(s_r.ptr);
  endproperty
  a_no_inc: assert property (p_no_inc)
    else $error("Pointer moved on a read that does not increment.");

  property p_addr_wr;
    @(posedge mclk) disable iff (srst)
    portal_hit_wr && s_r.fn == FN_ADDR |=>
      s_r.ptr[$past(s_r.extended_device_selector)] == $past(req.wdata);
  endproperty
  a_addr_wr: assert property (p_addr_wr)
    else $error("Address write did not reach the pointer.");

  property p_acc_rd;
    @(posedge mclk) disable iff (srst)
    req.rd && req.regad == REG_ACC_CTL |=>
      s_r.rdata == {$past(s_r.fn), $past(s_r.mid), $past(s_r.extended_device_selector)};
  endproperty
  a_acc_rd: assert property (p_acc_rd)
    else $error("Access control readback wrong.");

  property p_int_low;
    @(posedge mclk) disable iff (srst)
    !s_r.ctl2[CTL2_INTPOL] |=> int_pin == !$past(int_req);
  endproperty
  a_int_low: assert property (p_int_low)
    else $error("Active low interrupt pin wrong.");

  property p_ctl2_rest;
    @(posedge mclk) disable iff (srst)
    req.wr && req.regad == REG_CTL2 |=> ##1
      cfg.crossover_variant_select == $past(req.wdata[CTL2_XVAR], 2) &&
      cfg.jabber_en == $past(req.wdata[CTL2_JAB], 2) &&
      cfg.remote_loop == $past(req.wdata[CTL2_RLOOP], 2) &&
      cfg.sqe_test == $past(req.wdata[CTL2_SQE], 2) &&
      cfg.scram_bypass == $past(req.wdata[CTL2_SCRBYP], 2);
  endproperty
  a_ctl2_rest: assert property (p_ctl2_rest)
    else $error("Remaining control levels do not follow a write.");

  // Both increment codes must move the pointer on a portal write.
  property p_wr_inc;
    @(posedge mclk) disable iff (srst)
    portal_hit_wr && (s_r.fn == FN_INC_RW || s_r.fn == FN_INC_W) |=>
      s_r.ptr[$past(s_r.extended_device_selector)] == $past(s_r.ptr[s_r.extended_device_selector]) + 16'h0001;
  endproperty
  a_wr_inc: assert property (p_wr_inc)
    else $error("Pointer did not advance after a write.");

  property p_wr_hold;
    @(posedge mclk) disable iff (srst)
    portal_hit_wr && s_r.fn == FN_DATA |=> $stable(s_r.ptr);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("Pointer moved on a write without increment.");

  property p_data_rd;
    @(posedge mclk) disable iff (srst)
    portal_hit_rd && s_r.fn != FN_ADDR |=>
      s_r.rdata == $past(store_rdata);
  endproperty
  a_data_rd: assert property (p_data_rd)
    else $error("Portal data read did not return the stored word.");

endmodule : phyc_top

// ### tb/phyc_mgr_model.sv
// Station management model: sends clause 22 frames on MDC and MDIO.
// Assumes a pull-up on MDIO and the device drive pins of the bank.
`timescale 1ns/1ps

module phyc_mgr_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock
  input  wire logic mclk,
  // Management pins
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n
);
  logic m_oe;
  logic m_val;

  // The pull-up shows through whenever neither party drives the line.
  assign mdio_in = !mdio_oe_n ? mdio_out : (m_oe ? m_val : 1'b1);

  initial begin
    mdc   = 1'b0;
    m_oe  = 1'b0;
    m_val = 1'b1;
  end

  // MDC halves last four mclk cycles and MDC rests low between frames.
  task automatic frame(input logic [1:0] op, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [64:0] bits;
    bits = {32'hffffffff, 2'b01, op, PHY_ADDR, ra, 2'b10, wd, 1'b1};
    rd = 16'h0000;
    for (int i = 0; i < 65; i++) begin
      m_oe  = (op == 2'b01 || i < 46) && i < 64;
      m_val = bits[64-i];
      repeat (4) @(posedge mclk);
      #1;
      if (op == 2'b10 && i >= 48 && i < 64) rd = {rd[14:0], mdio_in};
      mdc = 1'b1;
      repeat (4) @(posedge mclk);
      #1 mdc = 1'b0;
    end
  endtask

endmodule // phyc_mgr_model

// ### tb/tb.sv
// Self-checking bench for the PHY control register bank.
// Assumes the management model is the only manager on MDIO.
`timescale 1ns/1ps

module tb;
  import phyc_pkg::*;

  localparam logic [4:0]  PHY = 5'h03;
  localparam logic [15:0] C2V [6] = '{16'h0000, 16'h6000, 16'h4000,
                                      16'h8800, 16'h0400, 16'h010f};
  localparam logic [9:0]  CFGV [6] = '{10'h100, 10'h080, 10'h100,
                                       10'h340, 10'h120, 10'h11f};

  logic       mclk;
  logic       srst;
  logic       strap;
  logic       mdc;
  logic       mdio_in;
  logic       mdio_out;
  logic       mdio_oe_n;
  logic       int_req;
  phyc_led_s  led_in;
  phyc_cfg_s  cfg;
  logic       int_pin;
  logic       ind_one;
  logic       ind_zero;
  int         mismatches = 0;
  int         n_compared = 0;
  int         cycles = 0;

  phyc_top #(.LED_MODE_RST(LED_ACT_LNK)) phyc_top_inst (
    .mclk(mclk), .srst(srst), .strap_pair_swap_dis(strap),
    .phy_addr(PHY), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .int_req(int_req), .led_in(led_in),
    .cfg(cfg), .int_pin(int_pin), .indicator_one(ind_one),
    .indicator_zero(ind_zero)
  );

  phyc_mgr_model #(.PHY_ADDR(PHY)) phyc_mgr_model_inst (
    .mclk(mclk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // About 30k cycles are needed; twice that means a hang.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic [9:0] e,
                         input logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    phyc_mgr_model_inst.frame(OP_WR, ra, d, unused);
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] ra,
                        input logic [15:0] e);
    logic [15:0] v;
    phyc_mgr_model_inst.frame(OP_RD, ra, 16'h0000, v);
    chk_reg(nm, e, v);
  endtask

  function automatic logic [1:0] led_exp(input logic [1:0] m,
                                         input phyc_led_s l);
    case (m)
      2'h0: return {l.speed_100, l.link_up | l.activity};
      2'h1: return {l.activity, l.link_up};
      default: return 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  initial begin
    srst = 1'b1;
    strap = 1'b1;
    int_req = 1'b0;
    led_in = 3'b000;
    repeat (6) @(posedge mclk);
    #1 srst = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rd_chk("ctl2 reset", REG_CTL2, 16'ha110);
    chk_pin("cfg reset", 10'h210, cfg);
    chk_pin("int idle", 10'h001, {9'h0, int_pin});
    rd_chk("acc reset", REG_ACC_CTL, 16'h0000);
    rd_chk("ptr reset", REG_PORTAL, 16'h0000);
    $display("test reset done");

    for (int i = 0; i < 6; i++) begin
      wr(REG_CTL2, C2V[i]);
      rd_chk("ctl2 readback", REG_CTL2, C2V[i]);
      chk_pin("cfg", CFGV[i], cfg);
    end
    int_req = 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk_pin("int low", 10'h000, {9'h0, int_pin});
    wr(REG_CTL2, 16'h0200);
    chk_pin("int high", 10'h001, {9'h0, int_pin});
    int_req = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk_pin("int off", 10'h000, {9'h0, int_pin});
    for (int m = 0; m < 4; m++) begin
      wr(REG_CTL2, 16'(m << 4));
      for (int p = 0; p < 2; p++) begin
        led_in = p ? 3'b011 : 3'b100;
        repeat (2) @(posedge mclk);
        #1 chk_pin("leds", {8'h0, led_exp(2'(m), led_in)},
                   {8'h0, ind_one, ind_zero});
      end
    end
    $display("test control done");

    wr(REG_ACC_CTL, 16'h0007);
    wr(REG_PORTAL, 16'h003c);
    wr(REG_ACC_CTL, 16'h4007);
    wr(REG_PORTAL, 16'h0002);
    rd_chk("acc", REG_ACC_CTL, 16'h4007);
    rd_chk("data", REG_PORTAL, 16'h0002);
    rd_chk("data again", REG_PORTAL, 16'h0002);
    wr(REG_ACC_CTL, 16'h0007);
    rd_chk("ptr fn01", REG_PORTAL, 16'h003c);
    wr(REG_ACC_CTL, 16'h001f);
    wr(REG_PORTAL, 16'h0019);
    wr(REG_ACC_CTL, 16'hc01f);
    for (int k = 1; k < 4; k++) wr(REG_PORTAL, 16'haa00 + 16'(k));
    wr(REG_ACC_CTL, 16'h001f);
    rd_chk("ptr fn11", REG_PORTAL, 16'h001c);
    wr(REG_PORTAL, 16'h0019);
    wr(REG_ACC_CTL, 16'hc01f);
    rd_chk("fn11 read", REG_PORTAL, 16'haa01);
    rd_chk("fn11 hold", REG_PORTAL, 16'haa01);
    wr(REG_ACC_CTL, 16'h801f);
    for (int k = 1; k < 4; k++)
      rd_chk("block", REG_PORTAL, 16'haa00 + 16'(k));
    wr(REG_ACC_CTL, 16'h001f);
    rd_chk("ptr fn10", REG_PORTAL, 16'h001c);
    wr(REG_ACC_CTL, 16'h0007);
    rd_chk("ptr dev7", REG_PORTAL, 16'h003c);
    wr(5'h05, 16'hffff);
    rd_chk("unmapped", 5'h05, 16'h0000);
    $display("test portal done");

    strap = 1'b0;
    srst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 srst = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rd_chk("ctl2 strap", REG_CTL2, 16'h8110);
    chk_pin("cfg strap", 10'h310, cfg);
    rd_chk("ptr rereset", REG_PORTAL, 16'h0000);
    $display("test strap done");
    final_report();
  end

endmodule // tb
